// ---- verilog/codec_serial_port.sv ----
// Codec serial port: control registers, bit clock, frame sync and serial shifting
//
// Behaviour
// - With stop-in-idle set the port freezes while the CPU is idle, otherwise it keeps running.
// - With loopback set the receiver reads the port's own serial output instead of the input pin.
// - With bit-clock direction set and the port enabled the bit-clock pin is an input from the codec.
// - With bit-clock direction clear and the port enabled the port drives the bit-clock pin.
// - Edge select set launches on falling and samples on rising edges, clear does the reverse.
// - With frame-sync direction set and the port enabled the frame-sync pin is an input.
// - With frame-sync direction clear and the port enabled the port generates and drives frame sync.
// - In disabled transmit slots the output floats when output-idle mode is set, else drives zero.
// - Words shift most significant bit first in both directions.
// - Received words shorter than sixteen bits are stored left justified with zero low bits.
//
// The plain strobed port and the register addresses are this design's own decisions.
`include "codec_port_consts.svh"

module codec_serial_port #(
    parameter int SLOTS = `DEFAULT_SLOTS,
    parameter int HALF_DIV = `SCK_HALF_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire codec_port_pkg::addr_t addr,
    input wire codec_port_pkg::word_t wdata,
    input wire logic wr,
    input wire logic rd,
    output codec_port_pkg::word_t rdata,
    input wire logic cpu_idle,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic fs_in,
    output logic fs_out,
    output logic fs_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe
);
    localparam codec_port_pkg::count_t LAST_SLOT = 4'(SLOTS - 1);
    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

    initial
    begin
        if (SLOTS < 1 || SLOTS > 11)
            $error("codec_serial_port: SLOTS must be 1 to 11");
        if (HALF_DIV < 1 || HALF_DIV > 255)
            $error("codec_serial_port: HALF_DIV must be 1 to 255");
    end

    codec_port_pkg::word_t ctrl_q, cfg_q, tx_hold_q, tx_sh_q, rx_acc_q, rx_data_q, rdata_q;
    logic tx_full_q, rx_full_q, underflow_q, overflow_q;
    logic [7:0] div_q;
    logic sck_int_q, sck_prev_q, fs_out_q, sdo_out_q, sdo_oe_q, sck_oe_q, fs_oe_q;
    codec_port_pkg::count_t bit_q, slot_q;
    logic [2:0] sync_q;

    sync_two #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d({sck_in, fs_in, sdi}),
        .q(sync_q)
    );

    // Address decode
    wire sel_ctrl = addr == `OFS_CTRL;
    wire sel_txd = addr == `OFS_TXD;
    wire sel_rxd = addr == `OFS_RXD;
    wire sel_stat = addr == `OFS_STAT;
    wire sel_cfg = addr == `OFS_CFG;

    wire port_enable = ctrl_q[`BIT_PORT_ENABLE];
    wire stop_in_idle = ctrl_q[`BIT_STOP_IN_IDLE];
    wire loopback_enable = ctrl_q[`BIT_LOOPBACK];
    wire bit_clock_direction = ctrl_q[`BIT_SCK_DIR];
    wire bit_clock_edge_select = ctrl_q[`BIT_SCK_EDGE];
    wire frame_sync_direction = ctrl_q[`BIT_FS_DIR];
    wire underflow_mode = ctrl_q[`BIT_UNDERFLOW_MODE];
    wire output_idle_mode = ctrl_q[`BIT_OUT_IDLE_MODE];
    wire justification_select = ctrl_q[`BIT_JUSTIFY];
    wire codec_port_pkg::count_t wl_last = cfg_q[`CFG_WL_LSB +: 4];

    wire run = port_enable & ~(stop_in_idle & cpu_idle);

    // Bit clock edges, internal divider or synchronised pin
    wire int_tick = run & ~bit_clock_direction & (div_q == DIV_LAST);
    wire ext_rise = run & bit_clock_direction & sync_q[2] & ~sck_prev_q;
    wire ext_fall = run & bit_clock_direction & ~sync_q[2] & sck_prev_q;
    wire sck_rise = ext_rise | (int_tick & ~sck_int_q);
    wire sck_fall = ext_fall | (int_tick & sck_int_q);
    wire launch = bit_clock_edge_select ? sck_fall : sck_rise;
    wire sample = bit_clock_edge_select ? sck_rise : sck_fall;

    wire fs_now = frame_sync_direction ? sync_q[1] : fs_out_q;
    wire fs_hit = sample & fs_now;

    // Position of the next launched bit
    wire last_bit = bit_q == wl_last;
    wire last_slot = slot_q == LAST_SLOT;
    wire codec_port_pkg::count_t nxt_bit = last_bit ? 4'h0 : bit_q + 4'h1;
    wire codec_port_pkg::count_t nxt_slot = last_bit ? (last_slot ? 4'h0 : slot_q + 4'h1) : slot_q;

    wire codec_port_pkg::count_t samp_bit = (fs_hit & justification_select) ? 4'h0 : bit_q;
    wire codec_port_pkg::count_t samp_slot = (fs_hit & justification_select) ? 4'h0 : slot_q;

    wire codec_port_pkg::word_t launch_mask = cfg_q >> (nxt_slot + 4'd4);
    wire codec_port_pkg::word_t samp_mask = cfg_q >> (samp_slot + 4'd4);
    wire launch_on = launch_mask[0];
    wire samp_on = samp_mask[0];

    wire tx_load = launch & launch_on & (nxt_bit == 4'h0);
    wire tx_under = tx_load & ~tx_full_q;
    wire codec_port_pkg::word_t tx_fill = (tx_full_q | underflow_mode) ? tx_hold_q : 16'h0000;
    wire codec_port_pkg::word_t tx_sh_d = tx_load ? tx_fill : {tx_sh_q[14:0], 1'b0};

    wire fs_gen = justification_select ? (nxt_bit == 4'h0 && nxt_slot == 4'h0)
                                       : (nxt_bit == wl_last && nxt_slot == LAST_SLOT);

    wire rx_bit = loopback_enable ? sdo_out_q : sync_q[0];
    wire codec_port_pkg::word_t rx_acc_d = ((samp_bit == 4'h0) ? 16'h0000 : rx_acc_q)
                                         | (rx_bit ? (16'h8000 >> samp_bit) : 16'h0000);
    wire rx_store = sample & samp_on & (samp_bit == wl_last);

    wire codec_port_pkg::word_t stat_w = {12'h000, overflow_q, underflow_q, rx_full_q, tx_full_q};
    wire codec_port_pkg::word_t rd_mux = sel_ctrl ? ctrl_q :
                                         sel_txd ? tx_hold_q :
                                         sel_rxd ? rx_data_q :
                                         sel_stat ? stat_w :
                                         sel_cfg ? cfg_q : 16'h0000;

    // Register file
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            ctrl_q <= `CTRL_RESET;
            cfg_q <= `CFG_RESET;
            rdata_q <= 16'h0000;
        end
        else
        begin
            if (wr && sel_ctrl)
                ctrl_q <= wdata & `CTRL_WMASK;
            if (wr && sel_cfg)
                cfg_q <= wdata;
            rdata_q <= rd ? rd_mux : 16'h0000;
        end
    end

    // Transmit holding word, received word and flags, set wins over clear
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            tx_hold_q <= 16'h0000;
            tx_full_q <= 1'b0;
            underflow_q <= 1'b0;
            overflow_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_data_q <= 16'h0000;
        end
        else
        begin
            if (wr && sel_txd)
                tx_hold_q <= wdata;
            tx_full_q <= (wr && sel_txd) | (tx_full_q & ~tx_load);
            underflow_q <= tx_under | (underflow_q & ~(wr && sel_stat && wdata[`STAT_UNDERFLOW]));
            overflow_q <= (rx_store & rx_full_q)
                        | (overflow_q & ~(wr && sel_stat && wdata[`STAT_OVERFLOW]));
            rx_full_q <= rx_store | (rx_full_q & ~(rd && sel_rxd));
            if (rx_store)
                rx_data_q <= rx_acc_d;
        end
    end

    // Bit clock divider and edge history
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !port_enable)
        begin
            div_q <= 8'h00;
            sck_int_q <= 1'b0;
        end
        else if (run && !bit_clock_direction)
        begin
            div_q <= int_tick ? 8'h00 : div_q + 8'h01;
            if (int_tick)
                sck_int_q <= ~sck_int_q;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            sck_prev_q <= 1'b0;
        else
            sck_prev_q <= sync_q[2];
    end

    // Frame position counters
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !port_enable)
        begin
            bit_q <= 4'h0;
            slot_q <= 4'h0;
        end
        else if (launch)
        begin
            bit_q <= nxt_bit;
            slot_q <= nxt_slot;
        end
        else if (fs_hit)
        begin
            bit_q <= justification_select ? 4'h0 : wl_last;
            slot_q <= justification_select ? 4'h0 : LAST_SLOT;
        end
    end

    // Serial shifting and pin drive
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !port_enable)
        begin
            tx_sh_q <= 16'h0000;
            rx_acc_q <= 16'h0000;
            sdo_out_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            fs_out_q <= 1'b0;
        end
        else
        begin
            if (launch)
            begin
                tx_sh_q <= tx_sh_d;
                sdo_out_q <= launch_on & tx_sh_d[15];
                sdo_oe_q <= launch_on | ~output_idle_mode;
                fs_out_q <= ~frame_sync_direction & fs_gen;
            end
            if (sample && samp_on)
                rx_acc_q <= rx_acc_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            sck_oe_q <= 1'b0;
            fs_oe_q <= 1'b0;
        end
        else
        begin
            sck_oe_q <= port_enable & ~bit_clock_direction;
            fs_oe_q <= port_enable & ~frame_sync_direction;
        end
    end

    assign rdata = rdata_q;
    assign sck_out = sck_int_q;
    assign sck_oe = sck_oe_q;
    assign fs_out = fs_out_q;
    assign fs_oe = fs_oe_q;
    assign sdo_out = sdo_out_q;
    assign sdo_oe = sdo_oe_q;
endmodule

// ---- verilog/codec_port_consts.svh ----
// Register offsets, field positions, reset values and timing counts of the codec serial port
`ifndef CODEC_PORT_CONSTS_SVH
`define CODEC_PORT_CONSTS_SVH

`define OFS_CTRL 8'h00
`define OFS_TXD 8'h04
`define OFS_RXD 8'h08
`define OFS_STAT 8'h0C
`define OFS_CFG 8'h10

`define BIT_PORT_ENABLE 15
`define BIT_STOP_IN_IDLE 13
`define BIT_LOOPBACK 11
`define BIT_SCK_DIR 10
`define BIT_SCK_EDGE 9
`define BIT_FS_DIR 8
`define BIT_UNDERFLOW_MODE 7
`define BIT_OUT_IDLE_MODE 6
`define BIT_JUSTIFY 5

`define CTRL_WMASK 16'hAFE3
`define CTRL_RESET 16'h0000
`define CFG_RESET 16'h001F
`define CFG_WL_LSB 0
`define CFG_MASK_LSB 4

`define STAT_TX_FULL 0
`define STAT_RX_FULL 1
`define STAT_UNDERFLOW 2
`define STAT_OVERFLOW 3

`define SCK_HALF_DIV 4
`define DEFAULT_SLOTS 4

`endif

// ---- verilog/codec_port_pkg.sv ----
// Types shared by the codec serial port design files
package codec_port_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0] addr_t;
    typedef logic [3:0] count_t;
endpackage

// ---- verilog/sync_two.sv ----
// Two flip-flop synchroniser for pin inputs
module sync_two #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    initial
    begin
        if (WIDTH < 1)
            $error("sync_two: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- sim/codec_serial_port_chk.sv ----
// Concurrent checks on the codec serial port pins
`include "codec_port_consts.svh"

module codec_serial_port_chk #(
    parameter int HALF_DIV = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire codec_port_pkg::addr_t addr,
    input wire codec_port_pkg::word_t wdata,
    input wire logic wr,
    input wire logic cpu_idle,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic fs_out,
    input wire logic fs_oe,
    input wire logic sdo_oe
);
    localparam int TOG_MAX = 2 * HALF_DIV + 4;
    codec_port_pkg::word_t ctrl_q;
    logic [9:0] fs_len_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            ctrl_q <= '0;
        else if (wr && addr == `OFS_CTRL)
            ctrl_q <= wdata & `CTRL_WMASK;
        fs_len_q <= fs_out ? fs_len_q + 10'h001 : 10'h000;
    end
    sequence s_sck_master;
        wr && addr == `OFS_CTRL && wdata[15] && !wdata[10];
    endsequence
    sequence s_fs_master;
        wr && addr == `OFS_CTRL && wdata[15] && !wdata[8];
    endsequence
    sequence s_idle_stop;
        (ctrl_q[15] && ctrl_q[13] && !ctrl_q[10] && cpu_idle)[*3];
    endsequence
    AST_SCK_DRIVEN: assert property (s_sck_master |-> ##[1:3] sck_oe)
        else $error("bit clock not driven");
    AST_SCK_INPUT: assert property (ctrl_q[15] && ctrl_q[10] && $past(ctrl_q[10]) |-> !sck_oe)
        else $error("bit clock driven as input");
    AST_FS_DRIVEN: assert property (s_fs_master |-> ##[1:3] fs_oe)
        else $error("frame sync not driven");
    AST_FS_INPUT: assert property (ctrl_q[15] && ctrl_q[8] && $past(ctrl_q[8]) |-> !fs_oe)
        else $error("frame sync driven as input");
    AST_FS_PULSE: assert property ($fell(fs_out) && ctrl_q[15] && !ctrl_q[8] && !ctrl_q[13]
        && $stable(ctrl_q) |-> fs_len_q == 2 * HALF_DIV)
        else $error("frame sync pulse length wrong");
    AST_IDLE_HALT: assert property (s_idle_stop |=> $stable(sck_out))
        else $error("bit clock runs in idle");
    AST_IDLE_RUN: assert property ((ctrl_q[15] && !ctrl_q[13] && !ctrl_q[10])[*2]
        |-> ##[1:TOG_MAX] ($changed(sck_out) || !ctrl_q[15]))
        else $error("bit clock stopped");
    AST_SDO_ZERO_MODE: assert property (ctrl_q[15] && !ctrl_q[6] && $stable(ctrl_q) && $past(sdo_oe)
        |-> sdo_oe)
        else $error("data output floats");
endmodule

bind codec_serial_port codec_serial_port_chk #(.HALF_DIV(HALF_DIV)) chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .cpu_idle(cpu_idle), .sck_out(sck_out), .sck_oe(sck_oe), .fs_out(fs_out),
    .fs_oe(fs_oe), .sdo_oe(sdo_oe));

// ---- sim/codec_partner_model.sv ----
// Behavioural external codec driving bit clock, frame sync and serial data
module codec_partner_model #(
    parameter int BITS = 32
) (
    input wire logic run,
    input wire logic fall_launch,
    input wire logic same_cycle,
    input wire logic [15:0] word,
    output logic sck,
    output logic fs,
    output logic sd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sck = 1'b1;
        fs = 1'b0;
        sd = 1'b0;
    end
    always
    begin
        wait (run);
        for (int b = 0; b < BITS; b++)
        begin
            sck = !fall_launch;
            fs = same_cycle ? (b == 0) : (b == BITS - 1);
            sd = (b < 16) ? word[15 - b] : !sd;
            #160;
            sck = fall_launch;
            #160;
        end
    end
endmodule

// ---- sim/codec_serial_port_tb.sv ----
// Self-checking bench for the codec serial port
`include "codec_port_consts.svh"
`define CHK(got, exp) \
begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
        n_fail++; \
        $display("unexpected %0t got %h exp %h", $time, got, exp); \
    end \
end

module codec_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    codec_port_pkg::addr_t addr = '0;
    codec_port_pkg::word_t wdata = '0;
    codec_port_pkg::word_t rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cpu_idle = 1'b0;
    logic run = 1'b0;
    logic m_fall = 1'b1;
    logic m_same = 1'b1;
    logic sck_out, sck_oe, fs_out, fs_oe, sdo_out, sdo_oe, m_sck, m_fs, m_sd;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    always #20 clk_sys = !clk_sys;
    codec_serial_port #(.SLOTS(2), .HALF_DIV(4)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cpu_idle(cpu_idle), .sck_in(sck_oe ? sck_out : m_sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .fs_in(fs_oe ? fs_out : m_fs), .fs_out(fs_out),
        .fs_oe(fs_oe), .sdi(m_sd), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    codec_partner_model #(.BITS(32)) partner_u (.run(run), .fall_launch(m_fall),
        .same_cycle(m_same), .word(16'h9B4E), .sck(m_sck), .fs(m_fs), .sd(m_sd));
    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            tally_and_finish;
        end
    end
    task automatic bus_wr(input codec_port_pkg::addr_t a, input codec_port_pkg::word_t d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic bus_rd(input codec_port_pkg::addr_t a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        // Read data stands in the cycle after the strobe
        @(posedge clk_sys);
        d = rdata;
    endtask
    task automatic wait_rx;
        logic [15:0] s;
        int k;
        s = '0;
        k = 0;
        while (s[`STAT_RX_FULL] !== 1'b1 && k < 800)
        begin
            bus_rd(`OFS_STAT, s);
            k++;
        end
        `CHK(s[`STAT_RX_FULL], 1'b1)
    endtask
    task automatic test_regs;
        logic [15:0] d;
        bus_rd(`OFS_CTRL, d);
        `CHK(d, `CTRL_RESET)
        bus_wr(`OFS_CTRL, 16'h7FFF);
        bus_rd(`OFS_CTRL, d);
        `CHK(d, 16'h2FE3)
        bus_wr(`OFS_CTRL, 16'h0000);
        bus_rd(8'h40, d);
        `CHK(d, 16'h0000)
        bus_rd(`OFS_CFG, d);
        `CHK(d, `CFG_RESET)
    endtask
    task automatic test_loop(input logic [1:0] i);
        logic [15:0] d;
        int k;
        int j;
        bus_wr(`OFS_CTRL, 16'h0000);
        bus_rd(`OFS_RXD, d);
        bus_wr(`OFS_STAT, 16'h000C);
        bus_wr(`OFS_CFG, 16'h0017);
        bus_wr(`OFS_TXD, 16'hA5C3);
        bus_wr(`OFS_CTRL, 16'h8800 | {6'h00, i[0], 1'b0, i[0], i[1], i[1], 5'h00});
        repeat (4) @(negedge clk_sys);
        `CHK({sck_oe, fs_oe}, 2'b11)
        @(posedge clk_sys);
        // First frame starts mid-word and is dropped
        wait_rx;
        bus_rd(`OFS_RXD, d);
        wait_rx;
        bus_rd(`OFS_RXD, d);
        `CHK(d, 16'hA500)
        bus_rd(`OFS_STAT, d);
        `CHK(d[`STAT_UNDERFLOW], 1'b0)
        wait_rx;
        bus_rd(`OFS_RXD, d);
        `CHK(d, i[0] ? 16'hA500 : 16'h0000)
        bus_rd(`OFS_STAT, d);
        `CHK(d[`STAT_UNDERFLOW], 1'b1)
        k = 0;
        j = 0;
        repeat (150)
        begin
            @(negedge clk_sys);
            k += (sdo_oe === 1'b0);
            j += (sdo_oe === 1'b0 && sdo_out !== 1'b0);
        end
        `CHK(k > 0, i[1])
        `CHK(j, 0)
        @(posedge clk_sys);
    endtask
    task automatic test_slave(input logic fl, input logic sc);
        logic [15:0] d;
        bus_wr(`OFS_CTRL, 16'h0000);
        bus_rd(`OFS_RXD, d);
        bus_wr(`OFS_CFG, 16'h001F);
        m_fall <= fl;
        m_same <= sc;
        bus_wr(`OFS_CTRL, 16'h8500 | {6'h00, fl, 3'h0, sc, 5'h00});
        run <= 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK({sck_oe, fs_oe}, 2'b00)
        @(posedge clk_sys);
        wait_rx;
        bus_rd(`OFS_RXD, d);
        wait_rx;
        bus_rd(`OFS_RXD, d);
        `CHK(d, 16'h9B4E)
        run <= 1'b0;
        // Let the codec finish its frame before the next mode
        repeat (260) @(posedge clk_sys);
    endtask
    task automatic test_idle;
        logic s;
        int k;
        for (int st = 1; st >= 0; st--)
        begin
            bus_wr(`OFS_CTRL, st ? 16'hA000 : 16'h8000);
            cpu_idle <= 1'b1;
            repeat (4) @(negedge clk_sys);
            s = sck_out;
            k = 0;
            repeat (40)
            begin
                @(negedge clk_sys);
                k += (sck_out !== s);
                s = sck_out;
            end
            `CHK(k == 0, st == 1)
            @(posedge clk_sys);
        end
        cpu_idle <= 1'b0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        test_regs;
        for (int i = 0; i < 4; i++)
            test_loop(2'(i));
        test_slave(1'b1, 1'b1);
        test_slave(1'b0, 1'b0);
        test_idle;
        tally_and_finish;
    end
endmodule
